// file: hdl/psd_top.sv
// shutdown, polarity, start-up order and dead-band stage of a 4-pin pwm
// assumes period timer and duty generator outside; inputs synchronous
`timescale 1ns/1ps
`default_nettype none
`include "psd_regs.svh"
//
// Overview of operation
// - pins float after reset until enabled
// - polarity per pair from low mode bits
// - period flag set when period starts
// - three-bit field selects shutdown sources
// - writing one to status forces shutdown
// - status bit 7 shows shutdown state
// - shutdown overrides outputs without period wait
// - pair a/c shutdown level: low, high, float
// - pair b/d shutdown level: low, high, float
// - shutdown is a level, persists while present
// - status writes ignored while condition present
// - without auto restart, software clears status
// - auto restart clears status when condition ends
// - restart resumes at next period start
// - dead-band only on rising active edge
// - dead-band is count times instruction cycle
// - long dead-band keeps output inactive
// - restart enable is bit 7 of control
module psd_top #(
   parameter int DB_W = 7
) (
   // clock and reset
   input  wire logic                  SYS_CLK_IN,
   input  wire logic                  RESETN_IN,
   // register port
   input  wire logic [`PSD_ADDR_W-1:0] REG_ADDR_IN,
   input  wire logic [7:0]            REG_WDATA_IN,
   input  wire logic                  REG_WR_IN,
   input  wire logic                  REG_RD_IN,
   output logic      [7:0]            REG_RDATA_OUT,
   // period timer and duty generator
   input  wire logic                  PERIOD_START_IN,
   input  wire logic                  PWM_RAW_IN,
   // shutdown sources
   input  wire logic                  CMP1_IN,
   input  wire logic                  CMP2_IN,
   input  wire logic                  SHDN_PIN_N_IN,
   // pins a,b,c,d in bits 0..3
   output logic      [3:0]            PWM_OUT,
   output logic      [3:0]            PWM_OE_N_OUT,
   output logic                       SHUTDOWN_OUT
);
   import psd_pkg::*;

   if (DB_W != 7) begin : g_bad_db_w
      $error("psd_top: dead-band field must be 7 bits");
   end

   logic [7:0]  shdn_ctrl_q;
   logic        status_q;
   logic [7:0]  epwm_ctrl_q;
   logic [7:0]  cpwm_ctrl_q;
   logic [3:0]  drive_en_q;
   logic        period_flag_q;
   logic [7:0]  rdata_q;
   psd_ostate_t state_q;
   logic [3:0]  pwm_q;
   logic [3:0]  oe_n_q;

   logic        cond;
   logic        sd;
   logic        auto_rs;
   logic [2:0]  src;
   logic [1:0]  mode;
   logic [3:0]  act;
   logic [1:0]  db_raw;
   logic [1:0]  db_out;
   logic [DB_W-1:0] db_cnt;
   logic        wr_shdn;
   logic        wr_flags;

   assign wr_shdn  = REG_WR_IN && REG_ADDR_IN == `PSD_OFF_SHDN_CTRL;
   assign wr_flags = REG_WR_IN && REG_ADDR_IN == `PSD_OFF_FLAGS;
   assign src      = shdn_ctrl_q[`PSD_SD_SRC_HI:`PSD_SD_SRC_LO];
   assign auto_rs  = epwm_ctrl_q[`PSD_RESTART_BIT];
   assign mode     = cpwm_ctrl_q[`PSD_MODE_HI:`PSD_MODE_LO];

   // condition is a live level, never latched
   assign cond = (src[0] & CMP1_IN) | (src[1] & CMP2_IN) | (src[2] & ~SHDN_PIN_N_IN);
   // live condition forces pins on the same edge that sets status
   assign sd = status_q | cond;

   // configuration registers
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         shdn_ctrl_q <= `PSD_RST_BYTE;
         epwm_ctrl_q <= `PSD_RST_BYTE;
         cpwm_ctrl_q <= `PSD_RST_BYTE;
         drive_en_q  <= `PSD_RST_DRIVE_EN;
      end else if (REG_WR_IN) begin
         case (REG_ADDR_IN)
            `PSD_OFF_SHDN_CTRL: shdn_ctrl_q <= {1'b0, REG_WDATA_IN[6:0]};
            `PSD_OFF_EPWM_CTRL: epwm_ctrl_q <= REG_WDATA_IN;
            `PSD_OFF_CPWM_CTRL: cpwm_ctrl_q <= REG_WDATA_IN;
            `PSD_OFF_DRIVE_EN:  drive_en_q  <= REG_WDATA_IN[3:0];
            default: ;
         endcase
      end
   end

   // shutdown status: hardware set beats every clear
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         status_q <= 1'b0;
      end else if (cond) begin
         status_q <= 1'b1;
      end else if (wr_shdn && REG_WDATA_IN[`PSD_SD_STATUS_BIT]) begin
         status_q <= 1'b1;
      end else if (auto_rs) begin
         status_q <= 1'b0;
      end else if (wr_shdn) begin
         status_q <= 1'b0;
      end
   end

   // period match flag, cleared by writing zero
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         period_flag_q <= 1'b0;
      end else if (PERIOD_START_IN) begin
         period_flag_q <= 1'b1;
      end else if (wr_flags && !REG_WDATA_IN[`PSD_PERIOD_FLAG_BIT]) begin
         period_flag_q <= 1'b0;
      end
   end

   // run state: waveform only starts on a period boundary
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_q <= PSD_IDLE;
      end else begin
         case (state_q)
            PSD_IDLE: begin
               if (sd) begin
                  state_q <= PSD_SHUT;
               end else if (PERIOD_START_IN) begin
                  state_q <= PSD_RUN;
               end
            end
            PSD_RUN: begin
               if (sd) begin
                  state_q <= PSD_SHUT;
               end
            end
            PSD_SHUT: begin
               if (!sd) begin
                  state_q <= PSD_IDLE;
               end
            end
            default: state_q <= PSD_IDLE;
         endcase
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rdata_q <= 8'h00;
      end else if (REG_RD_IN) begin
         case (REG_ADDR_IN)
            `PSD_OFF_SHDN_CTRL: rdata_q <= {status_q, shdn_ctrl_q[6:0]};
            `PSD_OFF_EPWM_CTRL: rdata_q <= epwm_ctrl_q;
            `PSD_OFF_CPWM_CTRL: rdata_q <= cpwm_ctrl_q;
            `PSD_OFF_DRIVE_EN:  rdata_q <= {4'h0, drive_en_q};
            `PSD_OFF_FLAGS:     rdata_q <= {6'h00, period_flag_q, 1'b0};
            `PSD_OFF_STATE:     rdata_q <= {5'h00, cond, state_q};
            default:            rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // dead-band applies to a and its complement b in half-bridge only
   assign db_cnt    = (mode == `PSD_MODE_HALF) ? epwm_ctrl_q[`PSD_DB_HI:0] : '0;
   assign db_raw[0] = PWM_RAW_IN;
   assign db_raw[1] = ~PWM_RAW_IN;

   // active-level waveform per pin, before polarity
   always_comb begin
      act = 4'h0;
      case (mode)
         `PSD_MODE_SINGLE:   act = {3'b000, PWM_RAW_IN};
         `PSD_MODE_HALF:     act = {2'b00, db_out[1], db_out[0]};
         `PSD_MODE_FULL_FWD: act = {PWM_RAW_IN, 2'b00, 1'b1};
         `PSD_MODE_FULL_REV: act = {1'b0, 1'b1, PWM_RAW_IN, 1'b0};
         default:            act = 4'h0;
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_db
         psd_deadband #(
            .CNT_W (DB_W),
            .INSN  (`PSD_INSN_CLKS)
         ) u_db (
            .clk_in   (SYS_CLK_IN),
            .rst_n_in (RESETN_IN),
            .count_in (db_cnt),
            .raw_in   (db_raw[gi]),
            .out_out  (db_out[gi])
         );
      end

      // even pins pair a/c, odd pins pair b/d
      for (gi = 0; gi < 4; gi++) begin : g_pin
         psd_pss_t pss;
         logic     pol_low;
         assign pss     = (gi % 2 == 0) ? shdn_ctrl_q[`PSD_SD_AC_HI:`PSD_SD_AC_LO]
                                        : shdn_ctrl_q[`PSD_SD_BD_HI:`PSD_SD_BD_LO];
         assign pol_low = (gi % 2 == 0) ? cpwm_ctrl_q[`PSD_POL_AC_BIT]
                                        : cpwm_ctrl_q[`PSD_POL_BD_BIT];
         // polarity change while driving is unguarded; software orders it
         always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
               pwm_q[gi]  <= 1'b0;
               oe_n_q[gi] <= 1'b1;
            end else if (!drive_en_q[gi]) begin
               pwm_q[gi]  <= pol_low;
               oe_n_q[gi] <= 1'b1;
            end else if (sd) begin
               pwm_q[gi]  <= pss[0];
               oe_n_q[gi] <= pss[1];
            end else if (state_q == PSD_RUN) begin
               pwm_q[gi]  <= act[gi] ^ pol_low;
               oe_n_q[gi] <= 1'b0;
            end else begin
               pwm_q[gi]  <= pol_low;
               oe_n_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign PWM_OUT       = pwm_q;
   assign PWM_OE_N_OUT  = oe_n_q;
   assign REG_RDATA_OUT = rdata_q;
   assign SHUTDOWN_OUT  = status_q;

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   sequence s_clear_ok;
      !cond && !auto_rs && status_q && !wr_shdn;
   endsequence

   property p_disabled_float;
      drive_en_q == 4'h0 |=> PWM_OE_N_OUT == 4'hF;
   endproperty
   a_disabled_float: assert property (p_disabled_float) else $error("pin driven while disabled");

   property p_flag;
      PERIOD_START_IN |=> period_flag_q;
   endproperty
   a_flag: assert property (p_flag) else $error("period flag not set");

   property p_cond_sets;
      cond |=> status_q ##0 SHUTDOWN_OUT;
   endproperty
   a_cond_sets: assert property (p_cond_sets) else $error("condition did not set status");

   property p_sw_set;
      wr_shdn && REG_WDATA_IN[7] |=> status_q;
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("software shutdown lost");

   property p_write_ignored;
      cond && wr_shdn && !REG_WDATA_IN[7] |=> status_q;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("status cleared under condition");

   property p_sticky;
      s_clear_ok |=> status_q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("status dropped without software");

   property p_auto;
      auto_rs && !cond && !wr_shdn |=> !status_q;
   endproperty
   a_auto: assert property (p_auto) else $error("auto restart did not clear");

   property p_next_period;
      state_q != PSD_RUN && !PERIOD_START_IN |=> state_q != PSD_RUN;
   endproperty
   a_next_period: assert property (p_next_period) else $error("resumed off period boundary");

   property p_pss_ac;
      sd && drive_en_q[0] |=> PWM_OE_N_OUT[0] == $past(shdn_ctrl_q[3])
                               && (PWM_OE_N_OUT[0] || PWM_OUT[0] == $past(shdn_ctrl_q[2]));
   endproperty
   a_pss_ac: assert property (p_pss_ac) else $error("pair a/c shutdown level wrong");

   property p_pss_bd;
      sd && drive_en_q[1] |=> PWM_OE_N_OUT[1] == $past(shdn_ctrl_q[1])
                               && (PWM_OE_N_OUT[1] || PWM_OUT[1] == $past(shdn_ctrl_q[0]));
   endproperty
   a_pss_bd: assert property (p_pss_bd) else $error("pair b/d shutdown level wrong");

   property p_read;
      REG_RD_IN && REG_ADDR_IN == `PSD_OFF_SHDN_CTRL |=> REG_RDATA_OUT[7] == $past(status_q);
   endproperty
   a_read: assert property (p_read) else $error("status read wrong");
endmodule
`default_nettype wire

// file: hdl/psd_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes the includer compiles it once per unit; guarded anyway
`ifndef PSD_REGS_SVH
`define PSD_REGS_SVH

// byte offsets on the plain register port
`define PSD_ADDR_W           3
`define PSD_OFF_SHDN_CTRL    3'h0
`define PSD_OFF_EPWM_CTRL    3'h1
`define PSD_OFF_CPWM_CTRL    3'h2
`define PSD_OFF_DRIVE_EN     3'h3
`define PSD_OFF_FLAGS        3'h4
`define PSD_OFF_STATE        3'h5

// auto_shutdown_control fields
`define PSD_SD_STATUS_BIT    7
`define PSD_SD_SRC_HI        6
`define PSD_SD_SRC_LO        4
`define PSD_SD_AC_HI         3
`define PSD_SD_AC_LO         2
`define PSD_SD_BD_HI         1
`define PSD_SD_BD_LO         0

// enhanced_pwm_control fields
`define PSD_RESTART_BIT      7
`define PSD_DB_HI            6

// capture_pwm_control fields
`define PSD_MODE_HI          7
`define PSD_MODE_LO          6
`define PSD_POL_AC_BIT       1
`define PSD_POL_BD_BIT       0
`define PSD_MODE_SINGLE      2'h0
`define PSD_MODE_FULL_FWD    2'h1
`define PSD_MODE_HALF        2'h2
`define PSD_MODE_FULL_REV    2'h3

// peripheral_flag_register field
`define PSD_PERIOD_FLAG_BIT  1

// reset values
`define PSD_RST_BYTE         8'h00
`define PSD_RST_DRIVE_EN     4'h0

// timing: dead-band counted in instruction cycles of 4 Tosc
`define PSD_CLK_PERIOD_NS    50
`define PSD_TOSC_NS          50
`define PSD_TOSC_PER_INSN    4
`define PSD_INSN_CLKS        ((`PSD_TOSC_PER_INSN * `PSD_TOSC_NS) / `PSD_CLK_PERIOD_NS)

`endif

// file: hdl/psd_pkg.sv
// types shared by the shutdown / dead-band output stage
// assumes psd_regs.svh supplies the numeric constants
package psd_pkg;
   typedef enum logic [1:0] {
      PSD_IDLE,
      PSD_RUN,
      PSD_SHUT
   } psd_ostate_t;

   typedef logic [1:0] psd_pss_t;
endpackage

// file: hdl/psd_deadband.sv
// dead-band delay for one output: delays only the inactive-to-active edge
// assumes raw_in and count_in synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
`include "psd_regs.svh"
module psd_deadband #(
   parameter int CNT_W = 7,
   parameter int INSN  = `PSD_INSN_CLKS
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // control
   input  wire logic [CNT_W-1:0] count_in,
   input  wire logic             raw_in,
   // result
   output logic                  out_out
);
   import psd_pkg::*;
   localparam int TW = CNT_W + $clog2(INSN) + 1;

   if (CNT_W < 1 || INSN < 1) begin : g_bad_param
      $error("psd_deadband: bad parameters");
   end

   logic [TW-1:0] tmr_q;
   logic          done_q;
   logic [TW-1:0] target;

   assign target = TW'(count_in) * TW'(INSN);

   // timer restarts on every fall, so a short pulse never shows
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tmr_q  <= '0;
         done_q <= 1'b0;
      end else if (!raw_in) begin
         tmr_q  <= '0;
         done_q <= 1'b0;
      end else if (!done_q) begin
         tmr_q <= tmr_q + TW'(1);
         if (tmr_q == target - TW'(1)) begin
            done_q <= 1'b1;
         end
      end
   end

   assign out_out = raw_in & ((count_in == '0) | done_q);

   sequence s_rise1;
      $rose(raw_in) && count_in == CNT_W'(1);
   endsequence

   property p_db_fall;
      @(posedge clk_in) disable iff (!rst_n_in)
         !raw_in |-> !out_out;
   endproperty
   a_db_fall: assert property (p_db_fall) else $error("delayed output active while raw inactive");

   property p_db_zero;
      @(posedge clk_in) disable iff (!rst_n_in)
         count_in == '0 |-> out_out == raw_in;
   endproperty
   a_db_zero: assert property (p_db_zero) else $error("zero dead-band added delay");

   property p_db_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
         s_rise1 |-> !out_out [*4];
   endproperty
   a_db_hold: assert property (p_db_hold) else $error("dead-band too short");

   property p_db_end;
      @(posedge clk_in) disable iff (!rst_n_in)
         (s_rise1 ##0 (raw_in && count_in == CNT_W'(1)) [*5]) |-> out_out;
   endproperty
   a_db_end: assert property (p_db_end) else $error("dead-band too long");
endmodule
`default_nettype wire

// file: verification/psd_bridge_model.sv
// switch-driver side of the four pwm pins, with board pull-downs
// assumes active-high gate inputs; tallies cycles where a and b both conduct
`timescale 1ns/1ps
`default_nettype none
module psd_bridge_model (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // pins from the output stage
   input  wire logic [3:0]  pwm_in,
   input  wire logic [3:0]  oe_n_in,
   // resolved pin levels and shoot-through tally
   output logic      [3:0]  pin_out,
   output logic      [15:0] overlap_out
);
   // a floated pin falls to the pull-down, so its switch stays off
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pin_out[k] = oe_n_in[k] ? 1'b0 : pwm_in[k];
      end
   end

   // both half-bridge switches on together would short the supply
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overlap_out <= 16'h0000;
      end else if (pin_out[0] && pin_out[1]) begin
         overlap_out <= overlap_out + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// file: verification/psd_top_tb.sv
// self-checking bench for the shutdown / dead-band output stage
// assumes psd_top and psd_bridge_model compiled first, header on the path
`timescale 1ns/1ps
`default_nettype none
`include "psd_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module psd_top_tb;
   localparam logic [3:0] OE_EXP  [3] = '{4'h0, 4'hA, 4'h5};
   localparam logic [3:0] PIN_EXP [3] = '{4'hA, 4'h5, 4'h0};
   localparam logic [3:0] ACT_EXP [4] = '{4'h1, 4'h9, 4'h1, 4'h6};
   logic        clk    = 1'b0;
   logic        rst_n  = 1'b0;
   logic [2:0]  addr   = 3'h0;
   logic [7:0]  wdata  = 8'h00;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic        pstart = 1'b0;
   logic        raw    = 1'b0;
   logic        cmp1   = 1'b0;
   logic        cmp2   = 1'b0;
   logic        pin_n  = 1'b1;
   wire  [7:0]  rdata;
   wire  [3:0]  pwm;
   wire  [3:0]  oe_n;
   wire  [3:0]  pins;
   wire  [15:0] overlap;
   wire         sd;
   int          miscompares = 0;
   int          num_checks  = 0;

   always #25 clk = ~clk;

   psd_top dut (
      .SYS_CLK_IN(clk), .RESETN_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .PERIOD_START_IN(pstart),
      .PWM_RAW_IN(raw), .CMP1_IN(cmp1), .CMP2_IN(cmp2), .SHDN_PIN_N_IN(pin_n),
      .PWM_OUT(pwm), .PWM_OE_N_OUT(oe_n), .SHUTDOWN_OUT(sd)
   );

   psd_bridge_model u_bridge (
      .clk_in(clk), .rst_n_in(rst_n), .pwm_in(pwm), .oe_n_in(oe_n),
      .pin_out(pins), .overlap_out(overlap)
   );

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse_start();
      @(posedge clk);
      pstart <= 1'b1;
      @(posedge clk);
      pstart <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // whole run is well under a thousand cycles; this is far past it
   initial begin
      #(50 * 20000);
      miscompares++;
      end_of_test();
   end

   initial begin
      logic [7:0]  d;
      logic [15:0] ov;
      int          i;
      int          j;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wait_cyc(1);
      `CHK(oe_n, 4'hF)
      `CHK(pins, 4'h0)
      `CHK(sd, 1'b0)
      wr_reg(3'h7, 8'hFF);
      for (i = 0; i < 8; i++) begin
         rd_reg(3'(i), d);
         `CHK(d, 8'h00)
      end
      $display("test reset done");

      wr_reg(`PSD_OFF_CPWM_CTRL, 8'h80);
      pulse_start();
      wait_cyc(1);
      rd_reg(`PSD_OFF_FLAGS, d);
      `CHK(d[1], 1'b1)
      wr_reg(`PSD_OFF_FLAGS, 8'h00);
      rd_reg(`PSD_OFF_FLAGS, d);
      `CHK(d[1], 1'b0)
      `CHK(oe_n, 4'hF)
      wr_reg(`PSD_OFF_DRIVE_EN, 8'h03);
      wait_cyc(2);
      `CHK(oe_n, 4'hC)
      @(posedge clk);
      raw <= 1'b1;
      wait_cyc(2);
      `CHK(pwm[1:0], 2'b01)
      @(posedge clk);
      raw <= 1'b0;
      wait_cyc(2);
      `CHK(pwm[1:0], 2'b10)
      $display("test start-up done");

      // drivers off around each polarity change
      for (i = 0; i < 5; i++) begin
         wr_reg(`PSD_OFF_DRIVE_EN, 8'h00);
         wr_reg(`PSD_OFF_CPWM_CTRL, 8'h80 | 8'(i % 4));
         wr_reg(`PSD_OFF_DRIVE_EN, 8'h03);
         @(posedge clk);
         raw <= 1'b1;
         wait_cyc(2);
         if (i < 4) `CHK(pwm[1:0], {i[0], ~i[1]})
         @(posedge clk);
         raw <= 1'b0;
      end
      $display("test polarity done");

      wr_reg(`PSD_OFF_EPWM_CTRL, 8'h03);
      ov = overlap;
      @(posedge clk);
      raw <= 1'b1;
      wait_cyc(2);
      `CHK(pwm[1:0], 2'b00)
      wait_cyc(8);
      `CHK(pwm[0], 1'b0)
      wait_cyc(5);
      `CHK(pwm[0], 1'b1)
      @(posedge clk);
      raw <= 1'b0;
      wait_cyc(2);
      `CHK(pwm[1:0], 2'b00)
      wait_cyc(8);
      `CHK(pwm[1], 1'b0)
      wait_cyc(5);
      `CHK(pwm[1], 1'b1)
      `CHK(overlap, ov)
      wr_reg(`PSD_OFF_EPWM_CTRL, 8'h7F);
      @(posedge clk);
      raw <= 1'b1;
      wait_cyc(30);
      `CHK(pwm[0], 1'b0)
      @(posedge clk);
      raw <= 1'b0;
      // count of one: a held low at three clocks and up by five; b only checked up after six
      wr_reg(`PSD_OFF_EPWM_CTRL, 8'h01);
      @(posedge clk);
      raw <= 1'b1;
      wait_cyc(3);
      `CHK(pwm[0], 1'b0)
      wait_cyc(2);
      `CHK(pwm[0], 1'b1)
      @(posedge clk);
      raw <= 1'b0;
      wait_cyc(6);
      `CHK(pwm[1], 1'b1)
      $display("test dead-band done");

      wr_reg(`PSD_OFF_EPWM_CTRL, 8'h80);
      for (i = 0; i < 8; i++) begin
         wr_reg(`PSD_OFF_SHDN_CTRL, {1'b0, 3'(i), 4'h0});
         for (j = 0; j < 3; j++) begin
            @(posedge clk);
            cmp1 <= (j == 0);
            cmp2 <= (j == 1);
            pin_n <= (j != 2);
            wait_cyc(4);
            `CHK(sd, 1'(i >> j))
            @(posedge clk);
            cmp1 <= 1'b0;
            cmp2 <= 1'b0;
            pin_n <= 1'b1;
            wait_cyc(3);
            `CHK(sd, 1'b0)
         end
      end
      $display("test sources done");

      wr_reg(`PSD_OFF_CPWM_CTRL, 8'h40);
      wr_reg(`PSD_OFF_DRIVE_EN, 8'h0F);
      for (i = 0; i < 3; i++) begin
         wr_reg(`PSD_OFF_SHDN_CTRL, {1'b0, 3'b100, 2'(i), 2'((i + 1) % 3)});
         @(posedge clk);
         pin_n <= 1'b0;
         wait_cyc(2);
         `CHK(oe_n, OE_EXP[i])
         `CHK(pins, PIN_EXP[i])
         @(posedge clk);
         pin_n <= 1'b1;
         wait_cyc(3);
      end
      $display("test shutdown states done");

      wr_reg(`PSD_OFF_DRIVE_EN, 8'h00);
      wr_reg(`PSD_OFF_CPWM_CTRL, 8'h80);
      wr_reg(`PSD_OFF_DRIVE_EN, 8'h03);
      wr_reg(`PSD_OFF_EPWM_CTRL, 8'h00);
      wr_reg(`PSD_OFF_SHDN_CTRL, 8'h40);
      @(posedge clk);
      pin_n <= 1'b0;
      raw <= 1'b1;
      wait_cyc(2);
      wr_reg(`PSD_OFF_SHDN_CTRL, 8'h40);
      rd_reg(`PSD_OFF_SHDN_CTRL, d);
      `CHK(d, 8'hC0)
      wait_cyc(1);
      `CHK(rdata, 8'h00)
      `CHK(pwm[0], 1'b0)
      @(posedge clk);
      pin_n <= 1'b1;
      wait_cyc(6);
      `CHK(sd, 1'b1)
      wr_reg(`PSD_OFF_SHDN_CTRL, 8'h40);
      wait_cyc(2);
      `CHK(sd, 1'b0)
      `CHK(pwm[0], 1'b0)
      pulse_start();
      wait_cyc(3);
      `CHK(pwm[0], 1'b1)
      wr_reg(`PSD_OFF_SHDN_CTRL, 8'hC0);
      wait_cyc(2);
      `CHK(sd, 1'b1)
      `CHK(pwm[1:0], 2'b00)
      wr_reg(`PSD_OFF_SHDN_CTRL, 8'h40);
      wait_cyc(2);
      `CHK(sd, 1'b0)
      $display("test firmware restart done");

      // every output mode with the waveform held active
      wr_reg(`PSD_OFF_DRIVE_EN, 8'h0F);
      pulse_start();
      for (i = 0; i < 4; i++) begin
         wr_reg(`PSD_OFF_CPWM_CTRL, 8'(i << 6));
         wait_cyc(2);
         `CHK(pwm, ACT_EXP[i])
         `CHK(oe_n, 4'h0)
      end
      $display("test modes done");
      end_of_test();
   end
endmodule
`undef CHK
`default_nettype wire
